// [shared/conv_pkg.sv]
// Notes on behaviour
// R1 - Four byte-wide code registers, low and high for each converter, written to update outputs.
// R2 - All four code registers read zero after reset.
// R3 - Code is right-justified: low holds bits 7..0, the low nibble of high holds bits 11..8.
// R4 - After reset both converters are disabled with outputs undriven until software enables them.
// R5 - Each converter picks supply or reference as its full scale, independently.
// R6 - Software keeps the ADC powered while a converter uses the reference range.
// R7 - Output spans zero at code zero to the selected full scale at code 4095.
// R8 - One mode bit sets both converters to 12-bit or 8-bit; 8-bit uses the low register.
// R9 - In 12-bit mode the output changes on the low byte write; write high first.
// R10 - With sync clear, writes are held; setting sync updates both; sync set updates per write.
// R11 - Each converter has its own power bit: 1 powers up, 0 powers down.
// R12 - Bits 7..4 of each high register are ignored when forming the code.
package conv_pkg;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NIB_W  = 4;

  localparam logic [7:0] ADDR_A_LOW  = 8'hF9;
  localparam logic [7:0] ADDR_A_HIGH = 8'hFA;
  localparam logic [7:0] ADDR_B_LOW  = 8'hFB;
  localparam logic [7:0] ADDR_B_HIGH = 8'hFC;
  localparam logic [7:0] ADDR_CTRL   = 8'hFD;

  localparam logic [7:0] CODE_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET  = 8'h04;
  localparam logic [7:0] READ_NONE   = 8'h00;

  localparam int unsigned BIT_MODE  = 7;
  localparam int unsigned BIT_RNG_B = 6;
  localparam int unsigned BIT_RNG_A = 5;
  localparam int unsigned BIT_CLR_B = 4;
  localparam int unsigned BIT_CLR_A = 3;
  localparam int unsigned BIT_SYNC  = 2;
  localparam int unsigned BIT_PWR_B = 1;
  localparam int unsigned BIT_PWR_A = 0;

  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [3:0]  NIB_ZERO  = 4'h0;
endpackage : conv_pkg

// [shared/conv_store_if.sv]
`timescale 1ns/1ps
interface conv_store_if;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] a_low;
  logic [7:0] a_high;
  logic [7:0] b_low;
  logic [7:0] b_high;

  modport ctrl  (output wr, output addr, output wdata,
                 input a_low, input a_high, input b_low, input b_high);
  modport store (input wr, input addr, input wdata,
                 output a_low, output a_high, output b_low, output b_high);
endinterface : conv_store_if

// [hw/conv_code_store.sv]
`timescale 1ns/1ps
module conv_code_store (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // Access from the control side
  conv_store_if.store st
);
  logic [7:0] a_low_r;
  logic [7:0] a_high_r;
  logic [7:0] b_low_r;
  logic [7:0] b_high_r;

  wire wr_a_low  = st.wr && (st.addr == conv_pkg::ADDR_A_LOW);
  wire wr_a_high = st.wr && (st.addr == conv_pkg::ADDR_A_HIGH);
  wire wr_b_low  = st.wr && (st.addr == conv_pkg::ADDR_B_LOW);
  wire wr_b_high = st.wr && (st.addr == conv_pkg::ADDR_B_HIGH);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      a_low_r  <= conv_pkg::CODE_RESET; // [R2]
      a_high_r <= conv_pkg::CODE_RESET; // [R2]
      b_low_r  <= conv_pkg::CODE_RESET; // [R2]
      b_high_r <= conv_pkg::CODE_RESET; // [R2]
    end else begin
      if (wr_a_low)  a_low_r  <= st.wdata; // [R1]
      if (wr_a_high) a_high_r <= st.wdata; // [R1]
      if (wr_b_low)  b_low_r  <= st.wdata; // [R1]
      if (wr_b_high) b_high_r <= st.wdata; // [R1]
    end
  end

  assign st.a_low  = a_low_r;
  assign st.a_high = a_high_r;
  assign st.b_low  = b_low_r;
  assign st.b_high = b_high_r;
endmodule : conv_code_store

// [hw/dual_dac_data_interface.sv]
`timescale 1ns/1ps
module dual_dac_data_interface (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // Special-function-register bus
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_rd_i,
  output logic      [7:0]  sfr_rdata_o,
  // Converter A
  output logic      [11:0] conv_a_code_o,
  output logic             conv_a_drive_en_o,
  output logic             conv_a_ref_avdd_o,
  // Converter B
  output logic      [11:0] conv_b_code_o,
  output logic             conv_b_drive_en_o,
  output logic             conv_b_ref_avdd_o
);
  conv_store_if st ();

  // Control register
  logic [7:0]  converter_control_reg_r;
  logic [7:0]  converter_control_reg_nxt;

  // Held codes, loaded by a sync step or an immediate low-byte write
  logic [11:0] active_a_r;
  logic [11:0] active_a_nxt;
  logic [11:0] active_b_r;
  logic [11:0] active_b_nxt;

  // Codes presented to the converters
  logic [11:0] out_a_r;
  logic [11:0] out_a_nxt;
  logic [11:0] out_b_r;
  logic [11:0] out_b_nxt;

  // Read path
  logic [7:0]  rdata_sel;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  // True when a bus strobe in this cycle targets the given register
  function automatic logic hits(input logic       strobe,
                                input logic [7:0] addr,
                                input logic [7:0] target);
    hits = strobe && (addr == target);
  endfunction : hits

  // Picks one field bit out of a control byte
  function automatic logic ctrl_bit(input logic [7:0]  ctrl,
                                    input int unsigned pos);
    ctrl_bit = ctrl[pos];
  endfunction : ctrl_bit

  // Builds the converter code from a low and high byte under the current mode
  function automatic logic [11:0] form_code(input logic [7:0] low,
                                            input logic [7:0] high,
                                            input logic       mode_8bit);
    if (mode_8bit)
      form_code = {low, conv_pkg::NIB_ZERO}; // [R8]
    else
      form_code = {high[conv_pkg::NIB_W-1:0], low}; // [R3] [R12]
  endfunction : form_code

  // A sync step and a low-byte write never share a cycle: one address per bus cycle
  function automatic logic [11:0] next_held(input logic [11:0] held,
                                            input logic        step,
                                            input logic [11:0] step_code,
                                            input logic        upd,
                                            input logic [11:0] upd_code);
    if (step)
      next_held = step_code;
    else if (upd)
      next_held = upd_code;
    else
      next_held = held;
  endfunction : next_held

  // Clear low forces zero volts without losing the held code
  function automatic logic [11:0] gate_clear(input logic [11:0] code,
                                             input logic        run);
    if (run)
      gate_clear = code;
    else
      gate_clear = conv_pkg::CODE_ZERO;
  endfunction : gate_clear

  // Byte store keeps every written bit, upper nibble of the high bytes included
  assign st.wr    = sfr_wr_i;
  assign st.addr  = sfr_addr_i;
  assign st.wdata = sfr_wdata_i;

  conv_code_store conv_code_store_inst (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .st         (st)
  );

  // Stored bytes as seen from this side
  wire [7:0]  held_a_low  = st.a_low;
  wire [7:0]  held_a_high = st.a_high;
  wire [7:0]  held_b_low  = st.b_low;
  wire [7:0]  held_b_high = st.b_high;

  // Register selects for this cycle's write
  wire        wr_ctrl   = hits(sfr_wr_i, sfr_addr_i, conv_pkg::ADDR_CTRL);
  wire        wr_a_low  = hits(sfr_wr_i, sfr_addr_i, conv_pkg::ADDR_A_LOW);
  wire        wr_b_low  = hits(sfr_wr_i, sfr_addr_i, conv_pkg::ADDR_B_LOW);

  // Control fields as held
  wire        mode_8bit = ctrl_bit(converter_control_reg_r, conv_pkg::BIT_MODE); // [R8]
  wire        sync_set  = ctrl_bit(converter_control_reg_r, conv_pkg::BIT_SYNC); // [R10]
  wire        run_a     = ctrl_bit(converter_control_reg_r, conv_pkg::BIT_CLR_A); // [R7]
  wire        run_b     = ctrl_bit(converter_control_reg_r, conv_pkg::BIT_CLR_B); // [R7]
  wire        pwr_a     = ctrl_bit(converter_control_reg_r, conv_pkg::BIT_PWR_A); // [R11]
  wire        pwr_b     = ctrl_bit(converter_control_reg_r, conv_pkg::BIT_PWR_B); // [R11]
  wire        avdd_a    = ctrl_bit(converter_control_reg_r, conv_pkg::BIT_RNG_A); // [R5]
  wire        avdd_b    = ctrl_bit(converter_control_reg_r, conv_pkg::BIT_RNG_B); // [R5]

  // Control fields carried by this cycle's write
  wire        sync_new  = ctrl_bit(sfr_wdata_i, conv_pkg::BIT_SYNC);
  wire        mode_new  = ctrl_bit(sfr_wdata_i, conv_pkg::BIT_MODE);

  // Held values go out only on a 0 to 1 step of the sync bit, not on every control write
  wire        sync_rise = wr_ctrl && sync_new && !sync_set; // [R10]
  wire        upd_a_low = wr_a_low && sync_set; // [R9] [R10]
  wire        upd_b_low = wr_b_low && sync_set; // [R9] [R10]

  // A control write replaces all eight bits at once
  assign converter_control_reg_nxt = wr_ctrl ? sfr_wdata_i : converter_control_reg_r; // [R5] [R8] [R11]

  // Converter A: immediate code uses the held mode, a sync step the mode just written
  wire [11:0] code_a_wr   = form_code(sfr_wdata_i, held_a_high, mode_8bit);
  wire [11:0] code_a_sync = form_code(held_a_low, held_a_high, mode_new);
  assign active_a_nxt = next_held(active_a_r, sync_rise, code_a_sync, upd_a_low, code_a_wr); // [R9] [R10]
  assign out_a_nxt    = gate_clear(active_a_r, run_a); // [R7]

  // Converter B, same arrangement
  wire [11:0] code_b_wr   = form_code(sfr_wdata_i, held_b_high, mode_8bit);
  wire [11:0] code_b_sync = form_code(held_b_low, held_b_high, mode_new);
  assign active_b_nxt = next_held(active_b_r, sync_rise, code_b_sync, upd_b_low, code_b_wr); // [R9] [R10]
  assign out_b_nxt    = gate_clear(active_b_r, run_b); // [R7]

  // Read data holds until the next read strobe
  assign rdata_nxt = sfr_rd_i ? rdata_sel : rdata_r;

  // Unmapped addresses read as zero
  always_comb begin
    case (sfr_addr_i)
      conv_pkg::ADDR_A_LOW:  rdata_sel = held_a_low;
      conv_pkg::ADDR_A_HIGH: rdata_sel = held_a_high;
      conv_pkg::ADDR_B_LOW:  rdata_sel = held_b_low;
      conv_pkg::ADDR_B_HIGH: rdata_sel = held_b_high;
      conv_pkg::ADDR_CTRL:   rdata_sel = converter_control_reg_r;
      default:               rdata_sel = conv_pkg::READ_NONE;
    endcase
  end

  // Reset leaves both converters powered down with sync set
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      converter_control_reg_r <= conv_pkg::CTRL_RESET; // [R4]
    end else begin
      converter_control_reg_r <= converter_control_reg_nxt;
    end
  end

  // Held codes
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      active_a_r <= conv_pkg::CODE_ZERO;
    end else begin
      active_a_r <= active_a_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      active_b_r <= conv_pkg::CODE_ZERO;
    end else begin
      active_b_r <= active_b_nxt;
    end
  end

  // Presented codes lag the held codes by one edge
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      out_a_r <= conv_pkg::CODE_ZERO;
    end else begin
      out_a_r <= out_a_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      out_b_r <= conv_pkg::CODE_ZERO;
    end else begin
      out_b_r <= out_b_nxt;
    end
  end

  // Read data register
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_r <= conv_pkg::READ_NONE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata_o       = rdata_r;

  // Converter A pins; the output stage is undriven while powered down
  assign conv_a_code_o     = out_a_r;
  assign conv_a_drive_en_o = pwr_a; // [R4] [R11]
  assign conv_a_ref_avdd_o = avdd_a; // [R5]

  // Converter B pins
  assign conv_b_code_o     = out_b_r;
  assign conv_b_drive_en_o = pwr_b; // [R4] [R11]
  assign conv_b_ref_avdd_o = avdd_b; // [R5]
endmodule : dual_dac_data_interface

// [bench/dual_dac_asserts.sv]
`timescale 1ns/1ps
module dual_dac_asserts (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // Register bus
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_rdata_o,
  // Converters
  input  wire logic [11:0] conv_a_code_o,
  input  wire logic        conv_a_drive_en_o,
  input  wire logic        conv_a_ref_avdd_o,
  input  wire logic [11:0] conv_b_code_o,
  input  wire logic        conv_b_drive_en_o,
  input  wire logic        conv_b_ref_avdd_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire cw = sfr_wr_i && sfr_addr_i == 8'hFD;
  a_pwr_a_follow: assert property (cw |=> conv_a_drive_en_o == $past(sfr_wdata_i[0])) else $error("pwr a");
  a_pwr_b_follow: assert property (cw |=> conv_b_drive_en_o == $past(sfr_wdata_i[1])) else $error("pwr b");
  a_rng_a_follow: assert property (cw |=> conv_a_ref_avdd_o == $past(sfr_wdata_i[5])) else $error("rng a");
  a_rng_b_follow: assert property (cw |=> conv_b_ref_avdd_o == $past(sfr_wdata_i[6])) else $error("rng b");
  a_unmapped_rd_zero: assert property (sfr_rd_i && (sfr_addr_i < 8'hF9 || sfr_addr_i > 8'hFD)
    |=> sfr_rdata_o == 8'h00) else $error("unmapped read");
  a_code_wr_back: assert property ((sfr_wr_i && sfr_addr_i == 8'hF9) ##2 (sfr_rd_i && sfr_addr_i == 8'hF9)
    |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("readback");
  a_code_a_cause: assert property ($changed(conv_a_code_o)
    |-> $past(sfr_wr_i) || $past(sfr_wr_i, 2) || $past(sfr_wr_i, 3)) else $error("code moved");
  a_clear_a_zero: assert property ((cw && !sfr_wdata_i[3]) ##1 !sfr_wr_i
    |=> conv_a_code_o == 12'h000) else $error("clear a");
endmodule : dual_dac_asserts

bind dual_dac_data_interface dual_dac_asserts dual_dac_asserts_inst (.core_clk_i, .sys_rst_i, .sfr_addr_i,
  .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .conv_a_code_o, .conv_a_drive_en_o, .conv_a_ref_avdd_o,
  .conv_b_code_o, .conv_b_drive_en_o, .conv_b_ref_avdd_o);

// [bench/tb_dual_dac_data_interface.sv]
`timescale 1ns/1ps
module tb_dual_dac_data_interface;
  logic        core_clk_i, sys_rst_i, sfr_wr_i, sfr_rd_i;
  logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [11:0] conv_a_code_o, conv_b_code_o;
  logic        conv_a_drive_en_o, conv_a_ref_avdd_o, conv_b_drive_en_o, conv_b_ref_avdd_o;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  dual_dac_data_interface dual_dac_data_interface_inst (.core_clk_i, .sys_rst_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .conv_a_code_o, .conv_a_drive_en_o, .conv_a_ref_avdd_o,
    .conv_b_code_o, .conv_b_drive_en_o, .conv_b_ref_avdd_o);
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Strobe drops on the next edge, so a following call always starts one edge later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= d;
    sfr_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i    <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_i   <= 1'b0;
    #1;
    chk({4'h0, sfr_rdata_o}, {4'h0, exp});
  endtask : rd
  // Two edges cover the held-code stage and the output stage
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : settle
  task automatic t_reset();
    for (int i = 0; i < 4; i++) rd(8'hF9 + i[7:0], 8'h00);
    rd(8'hFD, 8'h04);
    rd(8'hF8, 8'h00);
    chk({11'h0, conv_a_drive_en_o | conv_b_drive_en_o}, 12'h000);
    chk(conv_a_code_o | conv_b_code_o, 12'h000);
    $display("reset done");
  endtask : t_reset
  task automatic t_code12();
    wr(8'hFD, 8'h3F);
    chk({9'h0, conv_a_drive_en_o, conv_b_drive_en_o, conv_a_ref_avdd_o}, 12'h007);
    chk({11'h0, conv_b_ref_avdd_o}, 12'h000);
    wr(8'hFA, 8'hF7);
    wr(8'hF9, 8'hA5);
    rd(8'hF9, 8'hA5);
    chk(conv_a_code_o, 12'h7A5);
    rd(8'hFA, 8'hF7);
    wr(8'hFC, 8'hFF);
    wr(8'hFB, 8'hFF);
    settle();
    chk(conv_b_code_o, 12'hFFF);
    $display("code12 done");
  endtask : t_code12
  task automatic t_sync();
    wr(8'hFD, 8'h3B);
    wr(8'hFA, 8'h01);
    wr(8'hF9, 8'h23);
    wr(8'hFC, 8'h0E);
    wr(8'hFB, 8'h9C);
    settle();
    chk(conv_a_code_o, 12'h7A5);
    chk(conv_b_code_o, 12'hFFF);
    wr(8'hFD, 8'h3F);
    settle();
    chk(conv_a_code_o, 12'h123);
    chk(conv_b_code_o, 12'hE9C);
    $display("sync done");
  endtask : t_sync
  task automatic t_mode8();
    wr(8'hFD, 8'hBF);
    wr(8'hF9, 8'h5A);
    settle();
    chk(conv_a_code_o, 12'h5A0);
    wr(8'hFD, 8'hB7);
    settle();
    chk(conv_a_code_o, 12'h000);
    wr(8'hFD, 8'h00);
    chk({11'h0, conv_a_drive_en_o | conv_b_drive_en_o}, 12'h000);
    $display("mode8 done");
  endtask : t_mode8
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    sys_rst_i   = 1'b1;
    sfr_wr_i    = 1'b0;
    sfr_rd_i    = 1'b0;
    sfr_addr_i  = 8'h00;
    sfr_wdata_i = 8'h00;
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_code12();
    t_sync();
    t_mode8();
    conclude();
  end
endmodule : tb_dual_dac_data_interface
